// File: dv/stme_pin_model.sv
// Pin-side partner model that drives the external clock pin and the capture pin.
`timescale 1ns/10ps
module stme_pin_model (
  // Clock.
  input  wire logic clk,
  // Pins toward the timer.
  output logic      extClockPin,
  output logic      captureInPin
);
  // Both pins rest low until a pulse is asked for.
  initial begin
    extClockPin  = 1'b0;
    captureInPin = 1'b0;
  end

  // One high pulse of three clocks, wide enough never to be filtered.
  task pulse(input bit onCap);
    @(posedge clk);
    if (onCap) captureInPin <= 1'b1; else extClockPin <= 1'b1;
    repeat (3) @(posedge clk);
    if (onCap) captureInPin <= 1'b0; else extClockPin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
endmodule : stme_pin_model

// File: dv/stme_timer_chk.sv
// Checker of the timer's register port, pin enable, forced levels and flags.
`timescale 1ns/10ps
module stme_timer_chk
  import stme_pkg::*;
(
  // Clock and reset.
  input wire logic      clk,
  input wire logic      rstn,
  // Register port.
  input wire stme_req_t regReq,
  input wire logic [7:0] regRdata,
  // Pins and interrupts.
  input wire logic      waveOutPin,
  input wire logic      waveOutEn,
  input wire logic      compareAIrq,
  input wire logic      comparePIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] ctrl1Shadow_reg;
  // Shadow of the mode control register, taken from the writes on the port.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ctrl1Shadow_reg <= 8'h00;
    else if (regReq.wr && regReq.addr == STME_ADDR_CTRL1) ctrl1Shadow_reg <= regReq.wdata;
  end
  sequence s_rd(logic [2:0] a); regReq.rd && regReq.addr == a; endsequence
  sequence s_wr(logic [2:0] a); regReq.wr && regReq.addr == a; endsequence
  logic clrA;
  logic clrP;
  // Software clear requests of the two flags as seen on the port.
  assign clrA = regReq.wr && regReq.addr == STME_ADDR_FLAGS && regReq.wdata[STME_FLAG_A];
  assign clrP = regReq.wr && regReq.addr == STME_ADDR_FLAGS && regReq.wdata[STME_FLAG_P];
  property p_rdIdle; !regReq.rd |=> regRdata == 8'h00; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not zero outside a read answer");
  property p_cntHiPad; s_rd(STME_ADDR_CNTHI) |=> regRdata[7:2] == 6'h00; endproperty
  a_cntHiPad: assert property (p_cntHiPad) else $error("count high unused bits not zero");
  property p_cmpHiPad; s_rd(STME_ADDR_CMPAHI) |=> regRdata[7:2] == 6'h00; endproperty
  a_cmpHiPad: assert property (p_cmpHiPad) else $error("compare high unused bits not zero");
  property p_cmpRoundTrip;
    s_wr(STME_ADDR_CMPALO) ##1 s_rd(STME_ADDR_CMPALO) |=> regRdata == $past(regReq.wdata, 2);
  endproperty
  a_cmpRoundTrip: assert property (p_cmpRoundTrip) else $error("compare low byte readback wrong");
  property p_enMode; waveOutEn == !ctrl1Shadow_reg[STME_C1_MODELO]; endproperty
  a_enMode: assert property (p_enMode) else $error("pin enable does not follow mode");
  property p_force;
    ctrl1Shadow_reg[7:5] == 3'h4 |-> waveOutPin == ~(^ctrl1Shadow_reg[4:2]);
  endproperty
  a_force: assert property (p_force) else $error("forced pwm level wrong");
  property p_stickyA; compareAIrq && !clrA |=> compareAIrq; endproperty
  a_stickyA: assert property (p_stickyA) else $error("flag A dropped without a clear");
  property p_stickyP; comparePIrq && !clrP |=> comparePIrq; endproperty
  a_stickyP: assert property (p_stickyP) else $error("flag P dropped without a clear");
  property p_noPflag;
    $rose(comparePIrq) |-> !($past(ctrl1Shadow_reg[7:6]) == 2'h0 && $past(ctrl1Shadow_reg[0]));
  endproperty
  a_noPflag: assert property (p_noPflag) else $error("flag P raised with A clearing");
endmodule : stme_timer_chk
bind stme_timer stme_timer_chk u_chk (.clk(clk), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
  .waveOutPin(waveOutPin), .waveOutEn(waveOutEn), .compareAIrq(compareAIrq), .comparePIrq(comparePIrq));

// File: dv/stme_timer_tb.sv
// Self-checking testbench of the standard timer mode engine.
`timescale 1ns/10ps
module stme_timer_tb;
  import stme_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  stme_req_t  regReq = '0;
  logic [7:0] regRdata;
  logic       extClockPin, captureInPin, waveOutPin, waveOutEn, compareAIrq, comparePIrq;
  int         miscompares = 0;
  int         checksDone = 0;
  int         cycles = 0;
  // Clock of 8 ns and the hang guard.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  stme_timer u_dut (.clk(clk), .rstn(rstn), .regReq(regReq), .regRdata(regRdata), .extClockPin(extClockPin),
    .captureInPin(captureInPin), .waveOutPin(waveOutPin), .waveOutEn(waveOutEn),
    .compareAIrq(compareAIrq), .comparePIrq(comparePIrq));
  stme_pin_model u_pins (.clk(clk), .extClockPin(extClockPin), .captureInPin(captureInPin));

  task finish_test;
    $display("Mismatches %0d of %0d checks", miscompares, checksDone);
    if (miscompares == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task cmpv(input logic [9:0] got, input logic [9:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmpv
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) regReq <= '0;
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk) regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) regReq <= '0;
    #1 d = regRdata;
  endtask : rd
  // Stops the timer, clears flags, loads mode and compare A, then writes control 0.
  task setup(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
    wr(STME_ADDR_CTRL0, 8'h00);
    wr(STME_ADDR_FLAGS, 8'h03);
    wr(STME_ADDR_CTRL1, c1);
    wr(STME_ADDR_CMPALO, a[7:0]);
    wr(STME_ADDR_CMPAHI, {6'h00, a[9:8]});
    wr(STME_ADDR_CTRL0, c0);
  endtask : setup
  task waitIrq(input bit p, input int lim, output int n);
    n = 0;
    while (((p ? comparePIrq : compareAIrq) !== 1'b1) && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : waitIrq

  task automatic t_regs;
    logic [7:0] d;
    logic [2:0] adr [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    foreach (adr[i]) begin
      rd(adr[i], d);
      cmpv(d, 10'h000);
    end
    wr(STME_ADDR_CNTLO, 8'hFF);
    rd(STME_ADDR_CNTLO, d);
    cmpv(d, 10'h000);
    @(posedge clk) regReq <= '{addr: STME_ADDR_CMPALO, wdata: 8'hA5, wr: 1'b1, rd: 1'b0};
    @(posedge clk) regReq <= '{addr: STME_ADDR_CMPALO, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) regReq <= '0;
    #1 cmpv(regRdata, 10'h0A5);
    wr(STME_ADDR_CMPAHI, 8'hFF);
    rd(STME_ADDR_CMPAHI, d);
    cmpv(d, 10'h003);
  endtask : t_regs
  // Compare mode with A clearing: each pin action after one match.
  task automatic t_compare;
    int n;
    logic [7:0] d, e;
    logic [3:0] tbl [4] = '{4'b1101, 4'b0110, 4'b1001, 4'b0011};
    foreach (tbl[i]) begin
      setup({2'h0, tbl[i][3:2], tbl[i][1], 3'h1}, 10'h003, 8'h18);
      waitIrq(1'b0, 20, n);
      cmpv(n <= 8, 10'h001);
      cmpv(waveOutPin, tbl[i][0]);
    end
    rd(STME_ADDR_CNTLO, d);
    cmpv(d <= 8'h03, 10'h001);
    cmpv(comparePIrq, 10'h000);
    wr(STME_ADDR_CTRL0, 8'h00);
    rd(STME_ADDR_CNTLO, d);
    repeat (5) @(posedge clk);
    rd(STME_ADDR_CNTLO, e);
    cmpv(e, d);
    wr(STME_ADDR_FLAGS, 8'h01);
    #1 cmpv(compareAIrq, 10'h000);
  endtask : t_compare
  task t_zeroA;
    logic [7:0] c, d;
    setup(8'h31, 10'h000, 8'h18);
    wr(STME_ADDR_CTRL0, 8'h98);
    rd(STME_ADDR_CNTLO, c);
    repeat (5) @(posedge clk);
    rd(STME_ADDR_CNTLO, d);
    cmpv(d, c);
    wr(STME_ADDR_CTRL0, 8'h18);
    rd(STME_ADDR_CNTLO, d);
    cmpv(d, 8'(c + 8'h01));
    repeat (1100) @(posedge clk);
    cmpv(compareAIrq, 10'h000);
  endtask : t_zeroA
  task t_period;
    int n;
    setup(8'h30, 10'h005, 8'h19);
    waitIrq(1'b1, 200, n);
    cmpv(n >= 124 && n <= 134, 10'h001);
    cmpv(compareAIrq, 10'h001);
    setup(8'hF1, 10'h003, 8'h18);
    waitIrq(1'b0, 20, n);
    cmpv(compareAIrq, 10'h001);
    cmpv(waveOutEn, 10'h000);
  endtask : t_period
  // PWM: active cycles within one window for duty, swap, full duty and forcing.
  task automatic t_pwm;
    int n;
    logic [7:0] c1 [6] = '{8'hA8, 8'hA8, 8'hAA, 8'h88, 8'h98, 8'h9C};
    logic [9:0] a [6] = '{10'h040, 10'h100, 10'h100, 10'h040, 10'h040, 10'h040};
    int win [6] = '{128, 128, 256, 128, 128, 128};
    int exp [6] = '{64, 128, 128, 0, 128, 0};
    foreach (c1[i]) begin
      setup(c1[i], a[i], 8'h19);
      repeat (300) @(posedge clk);
      n = 0;
      repeat (win[i]) begin
        @(posedge clk);
        #1 n += (waveOutPin === 1'b1);
      end
      cmpv(n >= exp[i] - 3 && n <= exp[i] + 3, 10'h001);
    end
  endtask : t_pwm
  task t_pulse;
    int n;
    logic [7:0] d;
    setup(8'hB8, 10'h020, 8'h10);
    u_pins.pulse(1'b0);
    cmpv(waveOutPin, 10'h001);
    waitIrq(1'b0, 60, n);
    @(posedge clk);
    #1 cmpv(waveOutPin, 10'h000);
    rd(STME_ADDR_CTRL0, d);
    cmpv(d[STME_C0_RUN], 10'h000);
  endtask : t_pulse
  task t_capture;
    int n;
    logic [7:0] c, d;
    setup(8'h40, 10'h000, 8'h18);
    repeat (40) @(posedge clk);
    rd(STME_ADDR_CNTLO, c);
    u_pins.pulse(1'b1);
    waitIrq(1'b0, 6, n);
    cmpv(compareAIrq, 10'h001);
    rd(STME_ADDR_CMPALO, d);
    cmpv(d > c && d < c + 8'h0C, 10'h001);
    wr(STME_ADDR_CTRL1, 8'h70);
    wr(STME_ADDR_FLAGS, 8'h01);
    u_pins.pulse(1'b1);
    cmpv(compareAIrq, 10'h000);
    rd(STME_ADDR_CNTLO, c);
    rd(STME_ADDR_CNTLO, d);
    cmpv(d != c, 10'h001);
    wr(STME_ADDR_CTRL1, 8'h50);
    u_pins.pulse(1'b1);
    waitIrq(1'b0, 6, n);
    cmpv(compareAIrq, 10'h001);
  endtask : t_capture

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_compare();
    t_zeroA();
    t_period();
    t_pwm();
    t_pulse();
    t_capture();
    finish_test();
  end
endmodule : stme_timer_tb

// File: hw/stme_pkg.sv
// Package with register map, field positions and mode encodings of the standard timer.
package stme_pkg;

  // Register addresses (byte index on the plain register port).
  localparam logic [2:0] STME_ADDR_CTRL0  = 3'h0;
  localparam logic [2:0] STME_ADDR_CTRL1  = 3'h1;
  localparam logic [2:0] STME_ADDR_CNTLO  = 3'h2;
  localparam logic [2:0] STME_ADDR_CNTHI  = 3'h3;
  localparam logic [2:0] STME_ADDR_CMPALO = 3'h4;
  localparam logic [2:0] STME_ADDR_CMPAHI = 3'h5;
  localparam logic [2:0] STME_ADDR_FLAGS  = 3'h6;

  // Control register 0 field positions.
  localparam int STME_C0_HOLD  = 7;
  localparam int STME_C0_CKHI  = 6;
  localparam int STME_C0_CKLO  = 4;
  localparam int STME_C0_RUN   = 3;
  localparam int STME_C0_RPHI  = 2;
  localparam int STME_C0_RPLO  = 0;

  // Control register 1 field positions.
  localparam int STME_C1_MODEHI = 7;
  localparam int STME_C1_MODELO = 6;
  localparam int STME_C1_IOHI   = 5;
  localparam int STME_C1_IOLO   = 4;
  localparam int STME_C1_INIT   = 3;
  localparam int STME_C1_INV    = 2;
  localparam int STME_C1_SWAP   = 1;
  localparam int STME_C1_CLRSEL = 0;

  // Flag register bit positions; writing one clears a flag.
  localparam int STME_FLAG_A = 0;
  localparam int STME_FLAG_P = 1;

  // Reset values.
  localparam logic [7:0] STME_CTRL_RST = 8'h00;
  localparam logic [9:0] STME_CNT_RST  = 10'h000;

  // Counter geometry.
  localparam int         STME_CNT_W  = 10;
  localparam logic [9:0] STME_CNT_MAX = 10'h3FF;

  // Count clock sources.
  localparam logic [2:0] STME_CK_DIV4  = 3'h0;
  localparam logic [2:0] STME_CK_SYS   = 3'h1;
  localparam logic [2:0] STME_CK_DIV16 = 3'h2;
  localparam logic [2:0] STME_CK_DIV64 = 3'h3;
  localparam logic [2:0] STME_CK_EXTR  = 3'h6;
  localparam logic [2:0] STME_CK_EXTF  = 3'h7;

  // Operating modes.
  typedef enum logic [1:0] {
    STME_MODE_CMP  = 2'h0,
    STME_MODE_CAP  = 2'h1,
    STME_MODE_PWM  = 2'h2,
    STME_MODE_TMR  = 2'h3
  } stme_mode_t;

  // Pin action codes.
  localparam logic [1:0] STME_IO_00 = 2'h0;
  localparam logic [1:0] STME_IO_01 = 2'h1;
  localparam logic [1:0] STME_IO_10 = 2'h2;
  localparam logic [1:0] STME_IO_11 = 2'h3;

  // Register port request carried as one bundle.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stme_req_t;

endpackage : stme_pkg

// File: hw/stme_timer.sv
// Standard timer mode engine: counter, comparators, output pin and capture.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module stme_timer
  import stme_pkg::*;
#(
  parameter int CNT_W = STME_CNT_W
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rstn,
  // Register port.
  input  wire stme_req_t        regReq,
  output logic      [7:0]       regRdata,
  // Pins.
  input  wire logic             extClockPin,
  input  wire logic             captureInPin,
  output logic                  waveOutPin,
  output logic                  waveOutEn,
  // Interrupt requests.
  output logic                  compareAIrq,
  output logic                  comparePIrq
);

  logic [7:0]       ctrl0_reg;
  logic [7:0]       ctrl1_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] compareA_reg;
  logic             flagA_reg;
  logic             flagP_reg;
  logic             runDly_reg;
  logic             extDly_reg;
  logic             capDly_reg;
  logic [5:0]       prescale_reg;
  logic             pinLevel_reg;
  logic             pwmOut_reg;
  logic             capPend_reg;
  logic             capFlag_reg;
  logic             pulseEnd_reg;

  // Decoded control fields.
  stme_mode_t mode;
  logic [1:0] pinAction;
  logic [2:0] periodCoarse;
  logic [2:0] clkSel;
  logic       timerRun;
  logic       countHold;
  logic       outputInitialLevel;
  logic       outputInvert;
  logic       dutyPeriodSwap;
  logic       clearSourceSelect;

  assign mode               = stme_mode_t'(ctrl1_reg[STME_C1_MODEHI:STME_C1_MODELO]);
  assign pinAction          = ctrl1_reg[STME_C1_IOHI:STME_C1_IOLO];
  assign outputInitialLevel = ctrl1_reg[STME_C1_INIT];
  assign outputInvert       = ctrl1_reg[STME_C1_INV];
  assign dutyPeriodSwap     = ctrl1_reg[STME_C1_SWAP];
  assign clearSourceSelect  = ctrl1_reg[STME_C1_CLRSEL];
  assign periodCoarse       = ctrl0_reg[STME_C0_RPHI:STME_C0_RPLO];
  assign clkSel             = ctrl0_reg[STME_C0_CKHI:STME_C0_CKLO];
  assign timerRun           = ctrl0_reg[STME_C0_RUN];
  assign countHold          = ctrl0_reg[STME_C0_HOLD];

  // Count clock enable: internal divider or an edge of the external pin.
  // Sources 3 to 5 all take the /64 rate, as the slow clocks live outside this block.
  logic tick;
  logic extRise;
  logic extFall;
  assign extRise = extClockPin & ~extDly_reg;
  assign extFall = ~extClockPin & extDly_reg;
  always_comb begin
    if (clkSel == STME_CK_SYS) begin
      tick = 1'b1;
    end else if (clkSel == STME_CK_DIV4) begin
      tick = (prescale_reg[1:0] == 2'h3);
    end else if (clkSel == STME_CK_DIV16) begin
      tick = (prescale_reg[3:0] == 4'hF);
    end else if (clkSel == STME_CK_EXTR) begin
      tick = extRise;
    end else if (clkSel == STME_CK_EXTF) begin
      tick = extFall;
    end else begin
      tick = (prescale_reg == 6'h3F);
    end
  end

  // Free-running prescaler and edge history registers.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= 6'h00;
      extDly_reg   <= 1'b0;
      capDly_reg   <= 1'b0;
      runDly_reg   <= 1'b0;
    end else begin
      prescale_reg <= prescale_reg + 6'h01;
      extDly_reg   <= extClockPin;
      capDly_reg   <= captureInPin;
      runDly_reg   <= timerRun;
    end
  end

  // Run rising is seen against last cycle's run, so it lasts exactly one cycle.
  // That cycle clears the counter and presets the pin level and PWM state; counting starts one cycle later.
  logic runRise;
  assign runRise = timerRun & ~runDly_reg;

  // Comparator results.
  logic matchA;
  logic matchP;
  logic pwmMode;
  logic pulseMode;
  logic cmpLike;
  logic advance;
  assign pwmMode   = (mode == STME_MODE_PWM) && (pinAction != STME_IO_11);
  assign pulseMode = (mode == STME_MODE_PWM) && (pinAction == STME_IO_11);
  assign cmpLike   = (mode == STME_MODE_CMP) || (mode == STME_MODE_TMR);
  assign advance   = timerRun && !runRise && !countHold && tick;
  // P compares the top three bits of the next count, so a P period is exactly
  // coarse times 128 ticks; coarse 000 then matches at 3FF, which is overflow.
  logic [CNT_W-1:0] countInc;
  assign countInc = count_reg + CNT_W'(1);
  assign matchP = advance && (countInc[CNT_W-1:CNT_W-3] == periodCoarse)
                  && (countInc[CNT_W-4:0] == '0);
  assign matchA = advance && (compareA_reg != '0) && (count_reg == compareA_reg);

  // Period and duty thresholds for PWM.
  // One extra bit lets coarse 000 stand for the full 1024-tick span.
  logic [CNT_W:0] coarseSpan;
  logic [CNT_W:0] pwmPeriod;
  logic [CNT_W:0] pwmDuty;
  assign coarseSpan = (periodCoarse == 3'h0) ? {1'b1, {CNT_W{1'b0}}}
                      : {1'b0, periodCoarse, {(CNT_W-3){1'b0}}};
  assign pwmPeriod  = dutyPeriodSwap ? {1'b0, compareA_reg} : coarseSpan;
  assign pwmDuty    = dutyPeriodSwap ? coarseSpan : {1'b0, compareA_reg};

  // Clear condition per mode.
  // Single pulse mode never clears here; its counter restarts only on run rising.
  logic clearCnt;
  always_comb begin
    clearCnt = 1'b0;
    if (cmpLike) begin
      clearCnt = clearSourceSelect ? matchA : matchP;
    end else if (pwmMode) begin
      clearCnt = dutyPeriodSwap ? matchA : matchP;
    end else if (mode == STME_MODE_CAP) begin
      clearCnt = matchP;
    end
  end

  // Counter: cleared on run rising, held when stopped or paused.
  // With no clear it wraps from 3FF to zero by itself, which is the overflow.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= STME_CNT_RST;
    end else if (runRise) begin
      count_reg <= '0;
    end else if (advance) begin
      if (clearCnt) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + CNT_W'(1);
      end
    end
  end

  // Capture edge detection.
  // Edges are judged against the last sample, so very short glitches may be missed.
  logic capEdge;
  always_comb begin
    case (pinAction)
      STME_IO_00: capEdge = captureInPin & ~capDly_reg;
      STME_IO_01: capEdge = ~captureInPin & capDly_reg;
      STME_IO_10: capEdge = captureInPin ^ capDly_reg;
      default:    capEdge = 1'b0;
    endcase
  end

  // Capture pending waits for the next count tick, then latches.
  // Waiting for a tick keeps the stored value in step with the slow count rate.
  logic capLatch;
  assign capLatch = capPend_reg && tick;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capPend_reg <= 1'b0;
      capFlag_reg <= 1'b0;
    end else begin
      capFlag_reg <= capLatch;
      if (mode != STME_MODE_CAP || !timerRun) begin
        capPend_reg <= 1'b0;
      end else if (capEdge) begin
        capPend_reg <= 1'b1;
      end else if (capLatch) begin
        capPend_reg <= 1'b0;
      end
    end
  end

  // Flag events.
  logic setA;
  logic setP;
  assign setA = (mode == STME_MODE_CAP) ? capFlag_reg : matchA;
  assign setP = (cmpLike && !clearSourceSelect && matchP) || (pwmMode && matchP)
                || ((mode == STME_MODE_CAP) && matchP);

  // Control registers; single pulse end clears run, external edge sets it.
  // A software write to control 0 wins over both automatic changes of run.
  logic extTrig;
  assign extTrig = pulseMode && !timerRun && ((clkSel == STME_CK_EXTF) ? extFall : extRise);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl0_reg    <= STME_CTRL_RST;
      ctrl1_reg    <= STME_CTRL_RST;
      pulseEnd_reg <= 1'b0;
    end else begin
      pulseEnd_reg <= 1'b0;
      if (regReq.wr && regReq.addr == STME_ADDR_CTRL0) begin
        ctrl0_reg <= regReq.wdata;
      end else if (pulseMode && matchA) begin
        ctrl0_reg[STME_C0_RUN] <= 1'b0;
        pulseEnd_reg           <= 1'b1;
      end else if (extTrig) begin
        ctrl0_reg[STME_C0_RUN] <= 1'b1;
      end
      if (regReq.wr && regReq.addr == STME_ADDR_CTRL1) begin
        ctrl1_reg <= regReq.wdata;
      end
    end
  end

  // Compare-A storage: software writes or capture latch.
  // A capture wins over a software write in the same cycle; the write is lost.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compareA_reg <= '0;
    end else if (mode == STME_MODE_CAP && capLatch) begin
      compareA_reg <= count_reg;
    end else if (regReq.wr && regReq.addr == STME_ADDR_CMPALO) begin
      compareA_reg[7:0] <= regReq.wdata;
    end else if (regReq.wr && regReq.addr == STME_ADDR_CMPAHI) begin
      compareA_reg[CNT_W-1:8] <= regReq.wdata[CNT_W-9:0];
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle.
  // Losing a clear is safer than losing an event: software simply clears again.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flagA_reg <= 1'b0;
      flagP_reg <= 1'b0;
    end else begin
      if (setA) begin
        flagA_reg <= 1'b1;
      end else if (regReq.wr && regReq.addr == STME_ADDR_FLAGS && regReq.wdata[STME_FLAG_A]) begin
        flagA_reg <= 1'b0;
      end
      if (setP) begin
        flagP_reg <= 1'b1;
      end else if (regReq.wr && regReq.addr == STME_ADDR_FLAGS && regReq.wdata[STME_FLAG_P]) begin
        flagP_reg <= 1'b0;
      end
    end
  end

  assign compareAIrq = flagA_reg;
  assign comparePIrq = flagP_reg;

  // Compare-mode pin level and PWM/pulse active state.
  // The PWM level is registered, so the pin follows the count by one cycle.
  logic [CNT_W:0] countNext;
  assign countNext = {1'b0, count_reg};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinLevel_reg <= 1'b0;
      pwmOut_reg   <= 1'b0;
    end else if (runRise) begin
      pinLevel_reg <= outputInitialLevel;
      pwmOut_reg   <= 1'b1;
    end else begin
      if (mode == STME_MODE_CMP && matchA) begin
        case (pinAction)
          STME_IO_01: pinLevel_reg <= 1'b0;
          STME_IO_10: pinLevel_reg <= 1'b1;
          STME_IO_11: pinLevel_reg <= ~pinLevel_reg;
          default:    pinLevel_reg <= pinLevel_reg;
        endcase
      end
      if (pulseMode) begin
        if (!timerRun || pulseEnd_reg) begin
          pwmOut_reg <= 1'b0;
        end
      end else if (pwmMode) begin
        // Active from counter zero until the duty count; full when duty reaches period.
        pwmOut_reg <= (pwmDuty >= pwmPeriod) || (countNext < pwmDuty);
      end
    end
  end

  // Output pin selection; active level set by initial level, then inverted.
  // Timer and capture modes give the pin up to other functions and drop its enable.
  logic activeState;
  logic pinRaw;
  always_comb begin
    activeState = pwmOut_reg;
    if (pwmMode && pinAction == STME_IO_00) begin
      activeState = 1'b0;
    end else if (pwmMode && pinAction == STME_IO_01) begin
      activeState = 1'b1;
    end
    if (mode == STME_MODE_CMP) begin
      pinRaw = pinLevel_reg;
    end else if (mode == STME_MODE_PWM) begin
      pinRaw = outputInitialLevel ? activeState : ~activeState;
    end else begin
      pinRaw = 1'b0;
    end
  end

  assign waveOutPin = (mode == STME_MODE_PWM) ? (pinRaw ^ outputInvert)
                      : (pinRaw ^ (outputInvert && mode == STME_MODE_CMP));
  assign waveOutEn  = (mode == STME_MODE_CMP) || (mode == STME_MODE_PWM);

  // Register read path: data stands one cycle after the read strobe.
  // Writes to the count registers reach no storage and are thereby ignored.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regReq.rd) begin
      if (regReq.addr == STME_ADDR_CTRL0) begin
        regRdata <= ctrl0_reg;
      end else if (regReq.addr == STME_ADDR_CTRL1) begin
        regRdata <= ctrl1_reg;
      end else if (regReq.addr == STME_ADDR_CNTLO) begin
        regRdata <= count_reg[7:0];
      end else if (regReq.addr == STME_ADDR_CNTHI) begin
        regRdata <= {6'h00, count_reg[CNT_W-1:8]};
      end else if (regReq.addr == STME_ADDR_CMPALO) begin
        regRdata <= compareA_reg[7:0];
      end else if (regReq.addr == STME_ADDR_CMPAHI) begin
        regRdata <= {6'h00, compareA_reg[CNT_W-1:8]};
      end else if (regReq.addr == STME_ADDR_FLAGS) begin
        regRdata <= {6'h00, flagP_reg, flagA_reg};
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule : stme_timer
